// ---- nand_host_ctrl.sv ----
// Function
// - While busy the controller issues only status read or reset.
// - Controller never issues an opcode outside the defined command set.
// - After serial data input only column change, confirm, multi, cache or reset.
// - Pages of the last programmed block are programmed in ascending order only.
// - Ready/busy is open drain; the controller side supplies the pull-up (none here: READY_BUSY_N is a plain input the testbench drives high).
// - Controller never erases a block known to be bad.
// - Bad-block scan checks the marker in the first and second page.
// - Reads from column 0 get a one-bit-per-512-byte error report (byte, bit); RDATA is not corrected.
// - Failed program or erase retires the block.
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic REQ_VALID,
  input wire nand_host_pkg::request_type REQ,
  output logic REQ_READY,
  input wire logic WDATA_VALID,
  input wire logic [7:0] WDATA,
  output logic WDATA_READY,
  output logic RDATA_VALID,
  output logic [7:0] RDATA,
  input wire nand_host_pkg::ecc_code_type ECC_REF,
  output logic ECC_VALID,
  output nand_host_pkg::ecc_report_type ECC_REPORT,
  output logic DONE,
  output nand_host_pkg::result_type RESULT,
  output logic CLE,
  output logic ALE,
  output logic CE_N,
  output logic WE_N,
  output logic READ_STROBE_N,
  output logic WP_N,
  output logic [7:0] IO_OUT,
  output logic IO_OE_N,
  input wire logic [7:0] IO_IN,
  input wire logic READY_BUSY_N
);

  nand_host_pkg::state_type q;
  nand_host_pkg::state_type d;
  nand_host_pkg::ecc_code_type ecc_acc;
  nand_host_pkg::ecc_code_type syn;
  logic ecc_en;
  logic ecc_clr;
  logic [7:0] ecc_byte;
  logic [7:0] cmd1;
  logic legal;
  logic refuse;
  logic [nand_host_pkg::BLK_W-1:0] req_blk;

  function automatic nand_host_pkg::state_type start_wr(input nand_host_pkg::state_type s,
      input logic [7:0] b, input logic c, input logic a);
    nand_host_pkg::state_type r;
    r = s;
    r.io_out = b;
    r.cle = c;
    r.ale = a;
    r.we_n = 1'b0;
    r.io_oe_n = 1'b0;
    r.tcnt = 4'h0;
    return r;
  endfunction

  function automatic nand_host_pkg::state_type start_rd(input nand_host_pkg::state_type s);
    nand_host_pkg::state_type r;
    r = s;
    r.cle = 1'b0;
    r.ale = 1'b0;
    r.io_oe_n = 1'b1;
    r.re_n = 1'b0;
    r.tcnt = 4'h0;
    return r;
  endfunction

  function automatic nand_host_pkg::state_type finish(input nand_host_pkg::state_type s);
    nand_host_pkg::state_type r;
    r = s;
    r.st = nand_host_pkg::S_IDLE;
    r.done = 1'b1;
    r.req_ready = 1'b1;
    r.wd_ready = 1'b0;
    r.ce_n = 1'b1;
    r.wp_n = 1'b0;
    r.cle = 1'b0;
    r.ale = 1'b0;
    r.io_oe_n = 1'b1;
    return r;
  endfunction

  // Two column bytes then three row bytes; an erase sends only the row bytes
  function automatic logic [7:0] addr_byte(input logic [11:0] col, input logic [16:0] row,
      input logic [2:0] i);
    case (i)
      3'h0: addr_byte = col[7:0];
      3'h1: addr_byte = {4'h0, col[11:8]};
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      default: addr_byte = {7'h00, row[16]};
    endcase
  endfunction

  nand_ecc_seg ecc_i (
    .clk(CLK),
    .reset(RESET),
    .clear(ecc_clr),
    .enable(ecc_en),
    .index(q.bidx[8:0]),
    .data_in(ecc_byte),
    .acc(ecc_acc)
  );

  assign req_blk = REQ.row[nand_host_pkg::ROW_W-1:nand_host_pkg::PAGE_W];
  assign syn = ecc_acc ^ ECC_REF;

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.rd_valid = 1'b0;
    d.ecc_valid = 1'b0;
    ecc_en = 1'b0;
    ecc_clr = 1'b0;
    ecc_byte = 8'h00;
    cmd1 = nand_host_pkg::CMD_RESET;
    legal = 1'b1;
    refuse = 1'b0;
    // Shared strobe timing; the entry functions restart the count
    d.tcnt = q.tcnt + 4'h1;
    if (q.tcnt == nand_host_pkg::WE_RISE_AT) begin
      d.we_n = 1'b1;
    end
    if (q.tcnt == nand_host_pkg::RD_CAP_AT) begin
      d.re_n = 1'b1;
    end
    // Segment closed last cycle: the accumulator now holds its final value
    if (q.seg_pend) begin
      ecc_clr = 1'b1;
      d.seg_pend = 1'b0;
      d.ecc_valid = 1'b1;
      d.ecc_rep.seg = q.bidx[10:9];
      d.ecc_rep.code = ecc_acc;
      d.ecc_rep.correctable = (q.op == nand_host_pkg::OP_READ) && syn.par;
      d.ecc_rep.uncorrectable = (q.op == nand_host_pkg::OP_READ) && !syn.par && (syn != '0);
      d.ecc_rep.err_byte = syn.idx;
      d.ecc_rep.err_bit = syn.bitpos;
    end
    case (q.st)
      nand_host_pkg::S_IDLE: begin
        if (REQ_VALID && q.req_ready) begin
          case (REQ.op)
            nand_host_pkg::OP_RESET: cmd1 = nand_host_pkg::CMD_RESET;
            nand_host_pkg::OP_STATUS: cmd1 = nand_host_pkg::CMD_STATUS;
            nand_host_pkg::OP_READ: cmd1 = nand_host_pkg::CMD_READ_SETUP;
            nand_host_pkg::OP_SCAN: cmd1 = nand_host_pkg::CMD_READ_SETUP;
            nand_host_pkg::OP_PROG: cmd1 = nand_host_pkg::CMD_DATA_IN;
            nand_host_pkg::OP_ERASE: cmd1 = nand_host_pkg::CMD_ERASE_SETUP;
            default: legal = 1'b0;
          endcase
          if (REQ.op != nand_host_pkg::OP_RESET && REQ.op != nand_host_pkg::OP_STATUS) begin
            refuse = !q.init_done || !READY_BUSY_N;
          end
          if ((REQ.op == nand_host_pkg::OP_ERASE || REQ.op == nand_host_pkg::OP_PROG)
              && q.bad[req_blk]) begin
            refuse = 1'b1;
          end
          if (REQ.op == nand_host_pkg::OP_PROG && req_blk == q.prog_blk
              && {1'b0, REQ.row[nand_host_pkg::PAGE_W-1:0]} < q.next_page) begin
            refuse = 1'b1;
          end
          d.req_ready = 1'b0;
          d.op = REQ.op;
          d.row = REQ.row;
          d.col = REQ.col;
          d.bidx = 12'h000;
          d.scan_pg = 1'b0;
          d.seg_pend = 1'b0;
          d.result = '0;
          ecc_clr = 1'b1;
          if (!legal || refuse) begin
            d = finish(d);
            d.result.refused = 1'b1;
          end else begin
            d = start_wr(d, cmd1, 1'b1, 1'b0);
            d.st = nand_host_pkg::S_CMD1;
            d.ce_n = 1'b0;
            // Protect is lifted only around program and erase
            d.wp_n = (REQ.op == nand_host_pkg::OP_PROG || REQ.op == nand_host_pkg::OP_ERASE);
            if (REQ.op == nand_host_pkg::OP_SCAN) begin
              d.col = nand_host_pkg::MARK_COL;
              d.row = {req_blk, 6'h00};
            end
            if (REQ.op == nand_host_pkg::OP_PROG) begin
              d.prog_blk = req_blk;
              d.next_page = {1'b0, REQ.row[nand_host_pkg::PAGE_W-1:0]} + 7'h01;
            end
            if (REQ.op == nand_host_pkg::OP_ERASE && req_blk == q.prog_blk) begin
              d.next_page = 7'h00;
            end
          end
        end
      end
      nand_host_pkg::S_CMD1: begin
        if (q.tcnt == nand_host_pkg::WR_END_AT) begin
          if (q.op == nand_host_pkg::OP_STATUS) begin
            d = start_rd(d);
            d.st = nand_host_pkg::S_STAT_RD;
          end else if (q.op == nand_host_pkg::OP_RESET) begin
            d.st = nand_host_pkg::S_WAIT_WB;
            d.tcnt = 4'h0;
            d.io_oe_n = 1'b1;
            d.cle = 1'b0;
          end else begin
            d.aidx = (q.op == nand_host_pkg::OP_ERASE) ? nand_host_pkg::ROW_ADDR_FIRST : 3'h0;
            d = start_wr(d, addr_byte(q.col, q.row, d.aidx), 1'b0, 1'b1);
            d.st = nand_host_pkg::S_ADDR;
          end
        end
      end
      nand_host_pkg::S_ADDR: begin
        // Five address cycles at most; a sixth is never sent
        if (q.tcnt == nand_host_pkg::WR_END_AT) begin
          if (q.aidx != nand_host_pkg::ADDR_LAST) begin
            d.aidx = q.aidx + 3'h1;
            d = start_wr(d, addr_byte(q.col, q.row, d.aidx), 1'b0, 1'b1);
          end else if (q.op == nand_host_pkg::OP_PROG) begin
            d.st = nand_host_pkg::S_DATA_W;
            d.ale = 1'b0;
            d.wr_act = 1'b0;
            d.wd_ready = 1'b1;
          end else if (q.op == nand_host_pkg::OP_ERASE) begin
            d = start_wr(d, nand_host_pkg::CMD_ERASE_START, 1'b1, 1'b0);
            d.st = nand_host_pkg::S_CMD2;
          end else begin
            d = start_wr(d, nand_host_pkg::CMD_READ_START, 1'b1, 1'b0);
            d.st = nand_host_pkg::S_CMD2;
          end
        end
      end
      nand_host_pkg::S_DATA_W: begin
        if (!q.wr_act) begin
          if (WDATA_VALID && q.wd_ready) begin
            d = start_wr(d, WDATA, 1'b0, 1'b0);
            d.wd_ready = 1'b0;
            d.wr_act = 1'b1;
            ecc_en = (q.bidx < nand_host_pkg::DATA_BYTES);
            ecc_byte = WDATA;
            d.seg_pend = ecc_en && (q.bidx[8:0] == nand_host_pkg::SEG_LAST);
          end
        end else if (q.tcnt == nand_host_pkg::WR_END_AT) begin
          d.bidx = q.bidx + 12'h001;
          d.wr_act = 1'b0;
          if (q.bidx == nand_host_pkg::PAGE_BYTES - 12'h001) begin
            // Only the confirm may follow the data-input setup
            d = start_wr(d, nand_host_pkg::CMD_PROG_START, 1'b1, 1'b0);
            d.st = nand_host_pkg::S_CMD2;
          end else begin
            d.wd_ready = 1'b1;
          end
        end
      end
      nand_host_pkg::S_CMD2: begin
        if (q.tcnt == nand_host_pkg::WR_END_AT) begin
          d.st = nand_host_pkg::S_WAIT_WB;
          d.tcnt = 4'h0;
          d.io_oe_n = 1'b1;
          d.cle = 1'b0;
        end
      end
      nand_host_pkg::S_WAIT_WB: begin
        // Busy is not visible on the pin until the device has had time to pull it
        if (q.tcnt == nand_host_pkg::WB_END_AT) begin
          if (q.op == nand_host_pkg::OP_PROG || q.op == nand_host_pkg::OP_ERASE) begin
            d = start_wr(d, nand_host_pkg::CMD_STATUS, 1'b1, 1'b0);
            d.st = nand_host_pkg::S_STAT_CMD;
          end else begin
            d.st = nand_host_pkg::S_WAIT_RB;
          end
        end
      end
      nand_host_pkg::S_WAIT_RB: begin
        if (READY_BUSY_N) begin
          if (q.op == nand_host_pkg::OP_RESET) begin
            d = finish(d);
            d.init_done = 1'b1;
          end else begin
            d = start_rd(d);
            d.st = nand_host_pkg::S_DATA_R;
          end
        end
      end
      nand_host_pkg::S_STAT_CMD: begin
        if (q.tcnt == nand_host_pkg::WR_END_AT) begin
          d = start_rd(d);
          d.st = nand_host_pkg::S_STAT_RD;
        end
      end
      nand_host_pkg::S_STAT_RD: begin
        if (q.tcnt == nand_host_pkg::RD_CAP_AT) begin
          d.result.status = IO_IN;
        end
        if (q.tcnt == nand_host_pkg::RD_END_AT) begin
          if (q.op == nand_host_pkg::OP_STATUS) begin
            d = finish(d);
          end else if (!q.result.status[nand_host_pkg::ST_CACHE_READY]
                       || !q.result.status[nand_host_pkg::ST_PAGE_READY]) begin
            // Status stays selected, so another strobe polls again
            d = start_rd(d);
          end else begin
            d = finish(d);
            d.result.fail = q.result.status[nand_host_pkg::ST_FAIL];
            if (q.result.status[nand_host_pkg::ST_FAIL]) begin
              d.bad[q.row[nand_host_pkg::ROW_W-1:nand_host_pkg::PAGE_W]] = 1'b1;
            end
          end
        end
      end
      nand_host_pkg::S_DATA_R: begin
        if (q.tcnt == nand_host_pkg::RD_CAP_AT) begin
          d.rdata = IO_IN;
          if (q.op == nand_host_pkg::OP_READ) begin
            d.rd_valid = 1'b1;
            ecc_en = (q.col == 12'h000) && (q.bidx < nand_host_pkg::DATA_BYTES);
            ecc_byte = IO_IN;
            d.seg_pend = ecc_en && (q.bidx[8:0] == nand_host_pkg::SEG_LAST);
          end
        end
        if (q.tcnt == nand_host_pkg::RD_END_AT) begin
          if (q.op == nand_host_pkg::OP_SCAN) begin
            if (q.rdata != nand_host_pkg::GOOD_MARK) begin
              d.result.bad_found = 1'b1;
              d.bad[q.row[nand_host_pkg::ROW_W-1:nand_host_pkg::PAGE_W]] = 1'b1;
            end
            if (!q.scan_pg) begin
              d.scan_pg = 1'b1;
              d.row = {q.row[nand_host_pkg::ROW_W-1:nand_host_pkg::PAGE_W], 6'h01};
              d = start_wr(d, nand_host_pkg::CMD_READ_SETUP, 1'b1, 1'b0);
              d.st = nand_host_pkg::S_CMD1;
            end else begin
              d = finish(d);
            end
          end else if (q.col + q.bidx == nand_host_pkg::PAGE_BYTES - 12'h001) begin
            d = finish(d);
          end else begin
            d.bidx = q.bidx + 12'h001;
            d = start_rd(d);
          end
        end
      end
      default: begin
        d = finish(d);
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      q <= '0;
      q.st <= nand_host_pkg::S_IDLE;
      q.op <= nand_host_pkg::OP_RESET;
      q.ce_n <= 1'b1;
      q.we_n <= 1'b1;
      q.re_n <= 1'b1;
      q.io_oe_n <= 1'b1;
      q.req_ready <= 1'b1;
      q.next_page <= 7'h00;
    end else begin
      q <= d;
    end
  end

  assign REQ_READY = q.req_ready;
  assign WDATA_READY = q.wd_ready;
  assign RDATA_VALID = q.rd_valid;
  assign RDATA = q.rdata;
  assign ECC_VALID = q.ecc_valid;
  assign ECC_REPORT = q.ecc_rep;
  assign DONE = q.done;
  assign RESULT = q.result;
  assign CLE = q.cle;
  assign ALE = q.ale;
  assign CE_N = q.ce_n;
  assign WE_N = q.we_n;
  assign READ_STROBE_N = q.re_n;
  assign WP_N = q.wp_n;
  assign IO_OUT = q.io_out;
  assign IO_OE_N = q.io_oe_n;

endmodule
`default_nettype wire

// ---- nand_host_pkg.sv ----
package nand_host_pkg;

  // Pin timing, figures in ns, counts derived at the CLK rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_WP_NS = 12;
  localparam int T_WH_NS = 10;
  localparam int T_REA_NS = 20;
  localparam int T_REH_NS = 10;
  localparam int T_WB_NS = 100;
  localparam int WE_LOW_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_HIGH_CYC = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // One extra cycle so the captured byte has settled after the access time
  localparam int RE_LOW_CYC = (T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int RE_HIGH_CYC = (T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WE_RISE_AT = 4'(WE_LOW_CYC - 1);
  localparam logic [3:0] WR_END_AT = 4'(WE_LOW_CYC + WE_HIGH_CYC - 1);
  localparam logic [3:0] RD_CAP_AT = 4'(RE_LOW_CYC - 1);
  localparam logic [3:0] RD_END_AT = 4'(RE_LOW_CYC + RE_HIGH_CYC - 1);
  localparam logic [3:0] WB_END_AT = 4'(WB_CYC - 1);

  // Array geometry
  localparam int COL_W = 12;
  localparam int ROW_W = 17;
  localparam int PAGE_W = 6;
  localparam int BLK_W = 11;
  localparam int BLOCKS = 2048;
  localparam logic [11:0] PAGE_BYTES = 12'h840;
  localparam logic [11:0] DATA_BYTES = 12'h800;
  localparam logic [11:0] MARK_COL = 12'h800;
  localparam logic [8:0] SEG_LAST = 9'h1FF;
  localparam logic [2:0] ADDR_LAST = 3'h4;
  localparam logic [2:0] ROW_ADDR_FIRST = 3'h2;
  localparam logic [7:0] GOOD_MARK = 8'hFF;

  // Opcodes, the only values ever placed on the bus in a command cycle
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_START = 8'h30;
  localparam logic [7:0] CMD_DATA_IN = 8'h80;
  localparam logic [7:0] CMD_PROG_START = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_START = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;

  // Status byte bit positions
  localparam int ST_FAIL = 0;
  localparam int ST_PAGE_READY = 5;
  localparam int ST_CACHE_READY = 6;
  localparam int ST_UNPROTECTED = 7;

  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_STATUS = 3'h1,
    OP_READ = 3'h2,
    OP_PROG = 3'h3,
    OP_ERASE = 3'h4,
    OP_SCAN = 3'h5
  } op_type;

  typedef struct packed {
    op_type op;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } request_type;

  typedef struct packed {
    logic [7:0] status;
    logic fail;
    logic refused;
    logic bad_found;
  } result_type;

  typedef struct packed {
    logic par;
    logic [8:0] idx;
    logic [2:0] bitpos;
  } ecc_code_type;

  typedef struct packed {
    logic [1:0] seg;
    ecc_code_type code;
    logic correctable;
    logic uncorrectable;
    logic [8:0] err_byte;
    logic [2:0] err_bit;
  } ecc_report_type;

  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_CMD1 = 10'h002,
    S_ADDR = 10'h004,
    S_DATA_W = 10'h008,
    S_CMD2 = 10'h010,
    S_WAIT_WB = 10'h020,
    S_WAIT_RB = 10'h040,
    S_STAT_CMD = 10'h080,
    S_STAT_RD = 10'h100,
    S_DATA_R = 10'h200
  } state_enum_type;

  typedef struct packed {
    state_enum_type st;
    op_type op;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic [3:0] tcnt;
    logic [11:0] bidx;
    logic [2:0] aidx;
    logic wr_act;
    logic seg_pend;
    logic scan_pg;
    logic init_done;
    logic [BLK_W-1:0] prog_blk;
    logic [PAGE_W:0] next_page;
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic [7:0] io_out;
    logic io_oe_n;
    logic req_ready;
    logic wd_ready;
    logic rd_valid;
    logic [7:0] rdata;
    logic done;
    result_type result;
    logic ecc_valid;
    ecc_report_type ecc_rep;
    logic [BLOCKS-1:0] bad;
  } state_type;

endpackage

// ---- nand_ecc_seg.sv ----
`timescale 1ns/1ps
`default_nettype none
// Parity accumulator over one 512-byte segment; a single flipped bit shows
// as an odd overall parity and its byte and bit position as the syndrome.
module nand_ecc_seg (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic enable,
  input wire logic [8:0] index,
  input wire logic [7:0] data_in,
  output nand_host_pkg::ecc_code_type acc
);

  nand_host_pkg::ecc_code_type acc_q;
  nand_host_pkg::ecc_code_type acc_d;

  function automatic logic [2:0] set_bit_xor(input logic [7:0] b);
    logic [2:0] x;
    x = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        x = x ^ 3'(i);
      end
    end
    return x;
  endfunction

  always_comb begin
    acc_d = acc_q;
    if (clear) begin
      acc_d = '0;
    end else if (enable) begin
      acc_d.par = acc_q.par ^ (^data_in);
      acc_d.idx = acc_q.idx ^ ((^data_in) ? index : 9'h000);
      acc_d.bitpos = acc_q.bitpos ^ set_bit_xor(data_in);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign acc = acc_q;

endmodule
`default_nettype wire

// ---- nand_host_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module nand_host_monitor (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic REQ_VALID,
  input wire nand_host_pkg::request_type REQ,
  input wire logic REQ_READY,
  input wire logic DONE,
  input wire nand_host_pkg::result_type RESULT,
  input wire logic CLE,
  input wire logic CE_N,
  input wire logic WE_N,
  input wire logic READ_STROBE_N,
  input wire logic WP_N,
  input wire logic [7:0] IO_OUT,
  input wire logic IO_OE_N,
  input wire logic READY_BUSY_N
);
  logic we_q;
  logic seen_q;
  logic take;
  logic cmd;
  assign take = REQ_VALID && REQ_READY;
  // The device latches a command byte on the rising write strobe
  assign cmd = CLE && !CE_N && WE_N && !we_q;
  always_ff @(posedge CLK) begin
    we_q <= RESET ? 1'h1 : WE_N;
    seen_q <= RESET ? 1'h0 : (seen_q || (cmd && IO_OUT == 8'hFF));
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_done_single: assert property (DONE |=> !DONE)
    else $error("done pulse longer than one cycle");
  chk_ready_done: assert property ($rose(REQ_READY) |-> DONE)
    else $error("request ready rose without done");
  chk_bad_opcode: assert property (take && REQ.op[2:1] == 2'h3 |=> DONE && RESULT.refused && CE_N)
    else $error("undefined request not refused at once");
  chk_opcode_set: assert property (cmd |-> IO_OUT inside {8'h00, 8'h30, 8'h80, 8'h10,
    8'h60, 8'hD0, 8'h70, 8'hFF})
    else $error("command byte outside the command set");
  chk_busy_cmd: assert property (cmd && !READY_BUSY_N |-> IO_OUT inside {8'h70, 8'hFF})
    else $error("command other than status or reset while busy");
  chk_init_cmd: assert property (cmd && !seen_q |-> IO_OUT inside {8'h70, 8'hFF})
    else $error("command before first reset");
  chk_wp_high: assert property (cmd && IO_OUT inside {8'h10, 8'hD0} |-> WP_N)
    else $error("program or erase started while protected");
  chk_status_walk: assert property (take && REQ.op == nand_host_pkg::OP_STATUS
    |=> CLE && !CE_N && IO_OUT == 8'h70 ##7 DONE)
    else $error("status request walk wrong");
  chk_bus_turn: assert property (!READ_STROBE_N |-> IO_OE_N && !CE_N)
    else $error("bus driven during read strobe");
endmodule
bind nand_host_ctrl nand_host_monitor u_mon (.CLK(CLK), .RESET(RESET), .REQ_VALID(REQ_VALID),
  .REQ(REQ), .REQ_READY(REQ_READY), .DONE(DONE), .RESULT(RESULT), .CLE(CLE), .CE_N(CE_N),
  .WE_N(WE_N), .READ_STROBE_N(READ_STROBE_N), .WP_N(WP_N), .IO_OUT(IO_OUT),
  .IO_OE_N(IO_OE_N), .READY_BUSY_N(READY_BUSY_N));
`default_nettype wire

// ---- nand_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
  parameter int INIT_CYC = 60,
  parameter int BUSY_CYC = 20,
  parameter logic [10:0] BAD_BLK = 11'h005
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io,
  input wire logic fail_next,
  output logic [7:0] dq,
  output logic busy
);
  logic we_q;
  logic we_rise;
  logic status_mode;
  logic fail;
  logic init;
  logic [7:0] cnt;
  logic [2:0] acnt;
  logic [7:0] a2;
  logic [7:0] a3;
  logic a4;
  logic [7:0] val;
  assign we_rise = !we_q && we_n && !ce_n;
  assign busy = cnt != 8'h00;
  assign val = status_mode ? {wp_n, ~busy, ~busy, 4'h0, fail & ~busy}
    : (({a4, a3, a2[7:6]} == BAD_BLK) ? 8'h00 : 8'hFF);
  // Released bus shows the inverse so a stale byte can never pass
  assign dq = (!re_n && !ce_n) ? val : ~val;
  always_ff @(posedge clk) begin
    we_q <= we_n;
    if (reset) begin
      cnt <= 8'(INIT_CYC);
      init <= 1'h0;
      status_mode <= 1'h0;
      fail <= 1'h0;
      acnt <= 3'h0;
    end else begin
      if (busy) cnt <= cnt - 8'h01;
      if (we_rise && ale) begin
        if (acnt < 3'h5) acnt <= acnt + 3'h1;
        case (acnt)
          3'h2: a2 <= io;
          3'h3: a3 <= io;
          3'h4: a4 <= io[0];
          default: ;
        endcase
      end
      if (we_rise && cle && (init || io == 8'hFF || io == 8'h70)) begin
        case (io)
          8'hFF: begin
            cnt <= 8'h05;
            status_mode <= 1'h0;
            init <= 1'h1;
          end
          8'h70: status_mode <= 1'h1;
          8'h00: begin
            status_mode <= 1'h0;
            acnt <= 3'h0;
          end
          8'h80: acnt <= 3'h0;
          8'h60: acnt <= 3'h2;
          8'h30: cnt <= 8'(BUSY_CYC);
          8'h10, 8'hD0: begin
            cnt <= 8'(BUSY_CYC);
            fail <= fail_next | !wp_n;
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- nand_host_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("unexpected %s: expected %h, seen %h", nm, exp, got); \
    end \
  end
module nand_host_ctrl_tb;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic req_valid = 1'h0;
  nand_host_pkg::request_type req = '0;
  logic wdata_valid = 1'h0;
  logic [7:0] wdata = 8'h5A;
  nand_host_pkg::ecc_code_type ecc_ref = '0;
  logic hold_busy = 1'h0;
  logic fail_next = 1'h0;
  logic req_ready, wdata_ready, rdata_valid, ecc_valid, done;
  logic cle, ale, ce_n, we_n, re_n, wp_n, io_oe_n, dev_busy, rb_n;
  logic [7:0] rdata, io_out, dq, bus;
  nand_host_pkg::ecc_report_type ecc_report;
  nand_host_pkg::result_type result;
  nand_host_pkg::result_type res;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rd_count = 0;
  int ecc_count = 0;
  assign rb_n = (dev_busy || hold_busy) ? 1'h0 : 1'h1;
  assign bus = !io_oe_n ? io_out : dq;
  always #5 clk = ~clk;
  nand_host_ctrl u_dut (.CLK(clk), .RESET(reset), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(req_ready), .WDATA_VALID(wdata_valid), .WDATA(wdata), .WDATA_READY(wdata_ready),
    .RDATA_VALID(rdata_valid), .RDATA(rdata), .ECC_REF(ecc_ref), .ECC_VALID(ecc_valid),
    .ECC_REPORT(ecc_report), .DONE(done), .RESULT(result), .CLE(cle), .ALE(ale), .CE_N(ce_n),
    .WE_N(we_n), .READ_STROBE_N(re_n), .WP_N(wp_n), .IO_OUT(io_out), .IO_OE_N(io_oe_n),
    .IO_IN(bus), .READY_BUSY_N(rb_n));
  nand_dev_model u_dev (.clk(clk), .reset(reset), .cle(cle), .ale(ale), .ce_n(ce_n),
    .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io(bus), .fail_next(fail_next), .dq(dq),
    .busy(dev_busy));
  task automatic conclude;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Program of one full page plus polling stays far below this ceiling
  always @(negedge clk) begin
    cycles++;
    if (rdata_valid === 1'h1) rd_count++;
    if (ecc_valid === 1'h1) ecc_count++;
    if (cycles == 60000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic run(input logic [2:0] op, input int blk, input int pg, input logic [11:0] col);
    int n;
    n = 0;
    @(negedge clk);
    req.op = nand_host_pkg::op_type'(op);
    req.row = 17'(blk * 64 + pg);
    req.col = col;
    req_valid = 1'h1;
    // Ready is registered, so its value here still holds at the next rising edge
    while (req_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'h0;
    while (done !== 1'h1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    res = result;
  endtask
  task automatic t_init;
    run(nand_host_pkg::OP_PROG, 7, 0, 12'h000);
    `CHECK("early program refused", 1'h1, res.refused)
    run(nand_host_pkg::OP_STATUS, 0, 0, 12'h000);
    `CHECK("status during init", 8'h00, res.status)
  endtask
  task automatic t_reset;
    run(nand_host_pkg::OP_RESET, 0, 0, 12'h000);
    `CHECK("reset refused", 1'h0, res.refused)
    `CHECK("ready at reset end", 1'h1, rb_n)
    run(nand_host_pkg::OP_STATUS, 0, 0, 12'h000);
    `CHECK("idle status", 8'h60, res.status)
  endtask
  task automatic t_badop;
    run(3'h6, 0, 0, 12'h000);
    `CHECK("undefined op refused", 1'h1, res.refused)
  endtask
  task automatic t_busy;
    hold_busy = 1'h1;
    run(nand_host_pkg::OP_ERASE, 9, 0, 12'h000);
    `CHECK("erase while busy", 1'h1, res.refused)
    run(nand_host_pkg::OP_STATUS, 0, 0, 12'h000);
    `CHECK("status while busy", 1'h0, res.refused)
    hold_busy = 1'h0;
  endtask
  task automatic t_erase_fail;
    fail_next = 1'h1;
    run(nand_host_pkg::OP_ERASE, 3, 0, 12'h000);
    fail_next = 1'h0;
    `CHECK("failed erase status", 8'hE1, res.status)
    `CHECK("failed erase flag", 1'h1, res.fail)
    run(nand_host_pkg::OP_PROG, 3, 0, 12'h000);
    `CHECK("retired block program", 1'h1, res.refused)
  endtask
  task automatic t_scan;
    run(nand_host_pkg::OP_SCAN, 6, 0, 12'h000);
    `CHECK("good block scan", 1'h0, res.bad_found)
    run(nand_host_pkg::OP_SCAN, 5, 0, 12'h000);
    `CHECK("bad block scan", 1'h1, res.bad_found)
    run(nand_host_pkg::OP_ERASE, 5, 0, 12'h000);
    `CHECK("bad block erase", 1'h1, res.refused)
  endtask
  task automatic t_prog;
    ecc_count = 0;
    wdata_valid = 1'h1;
    run(nand_host_pkg::OP_PROG, 7, 2, 12'h000);
    wdata_valid = 1'h0;
    `CHECK("segment reports", 4, ecc_count)
    `CHECK("page program refused", 1'h0, res.refused)
    `CHECK("page program status", 8'hE0, res.status)
    run(nand_host_pkg::OP_PROG, 7, 1, 12'h000);
    `CHECK("lower page program", 1'h1, res.refused)
  endtask
  task automatic t_read;
    rd_count = 0;
    run(nand_host_pkg::OP_READ, 7, 2, 12'h83E);
    repeat (2) @(negedge clk);
    `CHECK("read byte count", 2, rd_count)
    `CHECK("read data", 8'hFF, rdata)
  endtask
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'h0;
    t_init();
    t_reset();
    t_badop();
    t_busy();
    t_erase_fail();
    t_scan();
    t_prog();
    t_read();
    conclude();
  end
endmodule
`default_nettype wire
